// file: ast_pkg.sv
// Constants, register map and types of the async serial core
// ============================================================
package ast_pkg;
   // =========================================================
   // Register offsets
   localparam logic [11:0] OFS_DATA = 12'h000;
   localparam logic [11:0] OFS_RSR = 12'h004;
   localparam logic [11:0] OFS_FLAG = 12'h018;
   localparam logic [11:0] OFS_IBRD = 12'h024;
   localparam logic [11:0] OFS_FBRD = 12'h028;
   localparam logic [11:0] OFS_LCRH = 12'h02c;
   localparam logic [11:0] OFS_CTL = 12'h030;
   localparam logic [11:0] OFS_IFLS = 12'h034;
   localparam logic [11:0] OFS_MASK = 12'h038;
   localparam logic [11:0] OFS_RIS = 12'h03c;
   localparam logic [11:0] OFS_MIS = 12'h040;
   localparam logic [11:0] OFS_ICR = 12'h044;
   // =========================================================
   // Reset values
   localparam logic [9:0] CTL_RST = 10'h300;
   localparam logic [5:0] IFLS_RST = 6'h12;
   // =========================================================
   // Field positions
   localparam int LC_BRK = 0;
   localparam int LC_PEN = 1;
   localparam int LC_EVEN = 2;
   localparam int LC_STP2 = 3;
   localparam int LC_FIFO = 4;
   localparam int LC_WL = 5;
   localparam int LC_STICK = 7;
   localparam int CT_EN = 0;
   localparam int CT_LOOP = 7;
   localparam int CT_TXON = 8;
   localparam int CT_RXON = 9;
   localparam int IR_RX = 4;
   localparam int IR_TX = 5;
   localparam int IR_RT = 6;
   localparam int IR_FE = 7;
   localparam int IR_PE = 8;
   localparam int IR_BE = 9;
   localparam int IR_OE = 10;
   // =========================================================
   // Counts
   localparam int CLK_HZ = 25000000;
   localparam int FIFO_DEPTH = 16;
   localparam logic [3:0] MID_TICK = 4'h7;
   localparam int BIT_TICKS = 16;
   localparam int RT_BITS = 32;
   localparam logic [9:0] RT_TICKS = 10'(RT_BITS * BIT_TICKS);
   // =========================================================
   // Types
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } ast_bus_t;
   typedef struct packed {
      logic oe;
      logic be;
      logic pe;
      logic fe;
      logic [7:0] data;
   } ast_rx_entry_t;
   typedef enum logic [2:0] {
      TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b011,
      TX_PAR = 3'b010, TX_STOP = 3'b110
   } ast_tx_state_t;
   typedef enum logic [2:0] {
      RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b011,
      RX_PAR = 3'b010, RX_STOP = 3'b110, RX_BRKW = 3'b111
   } ast_rx_state_t;
endpackage

// file: ast_baud.sv
// Fractional oversample tick generator
`timescale 1ns/1ns
module ast_baud
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Divisor in 1/64 units, 16 integer and 6 fraction bits
   input wire logic [21:0] divisor,
   // One-cycle tick at sixteen times the baud rate
   output logic tick
);
   import ast_pkg::*;
   typedef struct packed {
      logic [22:0] acc;
      logic tick;
   } ast_baud_state_t;
   ast_baud_state_t s;
   ast_baud_state_t n;
   logic [22:0] sum;

   // =========================================================
   // Accumulate 64 per clock, tick when the divisor is reached
   always_comb
   begin
      n = s;
      sum = s.acc + 23'd64;
      n.tick = 1'b0;
      // Divisor below one would tick every clock; hold instead
      if (divisor[21:6] == 16'h0000)
         n.acc = '0;
      else if (sum >= {1'b0, divisor})
      begin
         n.acc = sum - {1'b0, divisor};
         n.tick = 1'b1;
      end
      else
         n.acc = sum;
   end

   // State register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s <= '0;
      else
         s <= n;
   end

   assign tick = s.tick;
endmodule // ast_baud

// file: ast_fifo.sv
// Twelve-bit FIFO with single-entry mode
`timescale 1ns/1ns
module ast_fifo
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic push,
   input wire logic [11:0] din,
   // Drain side
   input wire logic pop,
   output logic [11:0] dout,
   // Mode and status
   input wire logic deep,
   output logic [4:0] count,
   output logic empty,
   output logic full
);
   import ast_pkg::*;
   typedef struct packed {
      logic [FIFO_DEPTH-1:0][11:0] mem;
      logic [3:0] rp;
      logic [3:0] wp;
      logic [4:0] cnt;
   } ast_fifo_state_t;
   ast_fifo_state_t s;
   ast_fifo_state_t n;
   logic [4:0] cap;
   logic do_push;
   logic do_pop;

   // Capacity is one entry unless the deep mode is on
   assign cap = deep ? 5'(FIFO_DEPTH) : 5'd1;
   assign full = s.cnt >= cap;
   assign empty = s.cnt == 5'd0;
   assign do_push = push && !full;
   assign do_pop = pop && !empty;

   // =========================================================
   // Pointer and count update
   always_comb
   begin
      n = s;
      if (do_push)
      begin
         n.mem[s.wp] = din;
         n.wp = s.wp + 4'd1;
      end
      if (do_pop)
         n.rp = s.rp + 4'd1;
      if (do_push && !do_pop)
         n.cnt = s.cnt + 5'd1;
      else if (do_pop && !do_push)
         n.cnt = s.cnt - 5'd1;
   end

   // State register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         s <= '0;
      else
         s <= n;
   end

   assign dout = s.mem[s.rp];
   assign count = s.cnt;
endmodule // ast_fifo

// file: ast_core.sv
// Async serial transmitter and receiver with register port
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module ast_core
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire ast_pkg::ast_bus_t bus,
   output logic [31:0] rdata,
   // Serial line
   input wire logic serial_in_port0,
   output logic serial_out_port0,
   // Combined interrupt request
   output logic irq
);
   import ast_pkg::*;

   typedef struct packed {
      logic [15:0] ibrd;
      logic [5:0] fbrd;
      logic [7:0] lcrh;
      logic [29:0] live;
      logic [9:0] ctl;
      logic [5:0] ifls;
      logic [10:0] mask;
      logic [10:0] ris;
      logic [3:0] rsr;
      logic [31:0] rdata;
      logic [1:0] sync;
      logic rx_prev;
      ast_tx_state_t txs;
      logic [3:0] txt;
      logic [2:0] txb;
      logic [7:0] txsh;
      logic txpar;
      logic tx2;
      logic txo;
      ast_rx_state_t rxs;
      logic [3:0] rxt;
      logic [2:0] rxb;
      logic [7:0] rxsh;
      logic rxpar;
      logic rxpe;
      logic rxzero;
      logic oe_pend;
      logic [9:0] rto;
   } ast_core_state_t;

   ast_core_state_t s;
   ast_core_state_t n;
   logic tick;
   logic [7:0] lc;
   logic [2:0] wl_last;
   logic rx_line;
   logic tx_end;
   logic rx_end;
   logic busy;
   logic [7:0] flags;
   logic [10:0] set_ev;
   logic [10:0] clr_ev;
   logic tx_push;
   logic tx_pop;
   logic [11:0] tx_head;
   logic [4:0] tx_count;
   logic tx_empty;
   logic tx_full;
   logic rx_push;
   logic rx_pop;
   logic brk;
   ast_rx_entry_t rx_wdata;
   ast_rx_entry_t rx_head;
   logic [4:0] rx_count;
   logic rx_empty;
   logic rx_full;

   // =========================================================
   // Helpers
   // Parity bit from running XOR; stick mode ignores the data
   function automatic logic par_bit(input logic [7:0] l,
                                    input logic p);
      if (l[LC_STICK])
         par_bit = !l[LC_EVEN];
      else
         par_bit = l[LC_EVEN] ? p : !p;
   endfunction

   // Threshold in entries for a level select code
   function automatic logic [4:0] level(input logic [2:0] sel);
      unique case (sel)
         3'd0: level = 5'(FIFO_DEPTH / 8);
         3'd1: level = 5'(FIFO_DEPTH / 4);
         3'd3: level = 5'(FIFO_DEPTH * 3 / 4);
         3'd4: level = 5'(FIFO_DEPTH * 7 / 8);
         default: level = 5'(FIFO_DEPTH / 2);
      endcase
   endfunction

   // =========================================================
   // Sub blocks
   // Only the live copy steers the generator and framing
   ast_baud u_baud
   (
      .clk(clk),
      .rst_n(rst_n),
      .divisor(s.live[29:8]),
      .tick(tick)
   );

   ast_fifo u_txf
   (
      .clk(clk),
      .rst_n(rst_n),
      .push(tx_push),
      .din({4'h0, bus.wdata[7:0]}),
      .pop(tx_pop),
      .dout(tx_head),
      .deep(lc[LC_FIFO]),
      .count(tx_count),
      .empty(tx_empty),
      .full(tx_full)
   );

   ast_fifo u_rxf
   (
      .clk(clk),
      .rst_n(rst_n),
      .push(rx_push),
      .din(rx_wdata),
      .pop(rx_pop),
      .dout(rx_head),
      .deep(lc[LC_FIFO]),
      .count(rx_count),
      .empty(rx_empty),
      .full(rx_full)
   );

   // =========================================================
   // Shared terms
   assign lc = s.live[7:0];
   assign wl_last = 3'd4 + lc[LC_WL+1:LC_WL];
   // Loopback hides the pin; the pin path stays synchronised
   assign rx_line = s.ctl[CT_LOOP] ? s.txo : s.sync[1];
   assign tx_end = tick && s.txt == 4'hf;
   assign rx_end = tick && s.rxt == 4'hf;
   assign busy = !tx_empty || s.txs != TX_IDLE;
   assign flags = {tx_empty, rx_full, tx_full, rx_empty, busy, 3'b000};
   assign tx_push = bus.wr && bus.addr == OFS_DATA;
   assign brk = s.rxzero && !rx_line;

   // =========================================================
   // Next-state logic
   always_comb
   begin
      n = s;
      set_ev = '0;
      clr_ev = '0;
      tx_pop = 1'b0;
      rx_push = 1'b0;
      rx_pop = 1'b0;
      rx_wdata = '0;
      n.sync = {s.sync[0], serial_in_port0};
      n.rx_prev = rx_line;
      n.rdata = '0;

      // Register writes
      if (bus.wr)
      begin
         case (bus.addr)
            OFS_RSR: n.rsr = '0;
            OFS_IBRD: n.ibrd = bus.wdata[15:0];
            OFS_FBRD: n.fbrd = bus.wdata[5:0];
            OFS_LCRH:
            begin
               n.lcrh = bus.wdata[7:0];
               n.live = {s.ibrd, s.fbrd, bus.wdata[7:0]};
            end
            OFS_CTL: n.ctl = bus.wdata[9:0];
            OFS_IFLS: n.ifls = bus.wdata[5:0];
            OFS_MASK: n.mask = bus.wdata[10:0];
            OFS_ICR: clr_ev = bus.wdata[10:0];
            default: ;
         endcase
      end

      // Register reads, answered the next cycle
      if (bus.rd)
      begin
         case (bus.addr)
            OFS_DATA:
            begin
               n.rdata = {20'h00000, rx_head};
               rx_pop = !rx_empty;
               n.rsr = s.rsr | {rx_head.oe, rx_head.be,
                                rx_head.pe, rx_head.fe};
            end
            OFS_RSR: n.rdata = {28'h0000000, s.rsr};
            OFS_FLAG: n.rdata = {24'h000000, flags};
            OFS_IBRD: n.rdata = {16'h0000, s.ibrd};
            OFS_FBRD: n.rdata = {26'h0000000, s.fbrd};
            OFS_LCRH: n.rdata = {24'h000000, s.lcrh};
            OFS_CTL: n.rdata = {22'h000000, s.ctl};
            OFS_IFLS: n.rdata = {26'h0000000, s.ifls};
            OFS_MASK: n.rdata = {21'h000000, s.mask};
            OFS_RIS: n.rdata = {21'h000000, s.ris};
            OFS_MIS: n.rdata = {21'h000000, s.ris & s.mask};
            default: n.rdata = '0;
         endcase
      end

      // Transmitter; enable is only looked at between frames
      n.txt = (s.txs == TX_IDLE) ? 4'h0 : s.txt + 4'(tick);
      unique case (s.txs)
         TX_IDLE:
         begin
            if (s.ctl[CT_EN] && s.ctl[CT_TXON] && !tx_empty)
            begin
               tx_pop = 1'b1;
               n.txsh = tx_head[7:0];
               n.txpar = 1'b0;
               n.txs = TX_START;
            end
         end
         TX_START:
            if (tx_end)
            begin
               n.txs = TX_DATA;
               n.txb = 3'd0;
            end
         TX_DATA:
            if (tx_end)
            begin
               n.txsh = s.txsh >> 1;
               n.txpar = s.txpar ^ s.txsh[0];
               n.txb = s.txb + 3'd1;
               n.tx2 = 1'b0;
               if (s.txb == wl_last)
                  n.txs = lc[LC_PEN] ? TX_PAR : TX_STOP;
            end
         TX_PAR:
            if (tx_end)
               n.txs = TX_STOP;
         TX_STOP:
            if (tx_end)
            begin
               if (lc[LC_STP2] && !s.tx2)
                  n.tx2 = 1'b1;
               else
                  n.txs = TX_IDLE;
            end
         default: n.txs = TX_IDLE;
      endcase
      // Line level registered with the state; break forces low
      unique case (n.txs)
         TX_START: n.txo = 1'b0;
         TX_DATA: n.txo = n.txsh[0];
         TX_PAR: n.txo = par_bit(lc, n.txpar);
         default: n.txo = 1'b1;
      endcase
      if (lc[LC_BRK])
         n.txo = 1'b0;

      // Receiver
      n.rxt = s.rxt + 4'(tick);
      unique case (s.rxs)
         RX_IDLE:
         begin
            n.rxt = 4'h0;
            if (s.ctl[CT_EN] && s.ctl[CT_RXON] && s.rx_prev &&
                !rx_line)
               n.rxs = RX_START;
         end
         RX_START:
            if (tick && s.rxt == MID_TICK)
            begin
               if (rx_line)
                  n.rxs = RX_IDLE;
               else
               begin
                  n.rxs = RX_DATA;
                  n.rxt = 4'h0;
                  n.rxb = 3'd0;
                  n.rxzero = 1'b1;
                  n.rxpar = 1'b0;
                  n.rxpe = 1'b0;
               end
            end
         RX_DATA:
            if (rx_end)
            begin
               n.rxsh = {rx_line, s.rxsh[7:1]};
               n.rxpar = s.rxpar ^ rx_line;
               n.rxzero = s.rxzero && !rx_line;
               n.rxb = s.rxb + 3'd1;
               if (s.rxb == wl_last)
                  n.rxs = lc[LC_PEN] ? RX_PAR : RX_STOP;
            end
         RX_PAR:
            if (rx_end)
            begin
               n.rxpe = rx_line != par_bit(lc, s.rxpar);
               n.rxzero = s.rxzero && !rx_line;
               n.rxs = RX_STOP;
            end
         RX_STOP:
            if (rx_end)
            begin
               // Status travels with the word
               rx_wdata.oe = s.oe_pend;
               rx_wdata.be = brk;
               rx_wdata.pe = s.rxpe;
               rx_wdata.fe = !rx_line;
               rx_wdata.data = brk ? 8'h00 :
                               s.rxsh >> (3'd7 - wl_last);
               set_ev[IR_FE] = !rx_line;
               set_ev[IR_PE] = s.rxpe;
               set_ev[IR_BE] = brk;
               if (rx_full)
               begin
                  // Word is lost; the next stored word carries it
                  set_ev[IR_OE] = 1'b1;
                  n.rsr[3] = 1'b1;
                  n.oe_pend = 1'b1;
               end
               else
               begin
                  rx_push = 1'b1;
                  n.oe_pend = 1'b0;
               end
               n.rxs = brk ? RX_BRKW : RX_IDLE;
            end
         RX_BRKW:
            if (rx_line)
               n.rxs = RX_IDLE;
         default: n.rxs = RX_IDLE;
      endcase

      // Receive timeout while data waits and the line is quiet
      if (rx_empty || s.rxs != RX_IDLE || rx_pop)
         n.rto = '0;
      else if (tick && s.rto != RT_TICKS)
      begin
         n.rto = s.rto + 10'd1;
         set_ev[IR_RT] = s.rto == RT_TICKS - 10'd1;
      end

      // Level events
      set_ev[IR_TX] = lc[LC_FIFO] ? tx_count <= level(s.ifls[2:0])
                                  : tx_empty;
      set_ev[IR_RX] = lc[LC_FIFO] ? rx_count >= level(s.ifls[5:3])
                                  : !rx_empty;
      // Set wins over a clear in the same cycle
      n.ris = (s.ris & ~clr_ev) | set_ev;
   end

   // =========================================================
   // State register
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
         s.ctl <= CTL_RST;
         s.ifls <= IFLS_RST;
         s.sync <= 2'b11;
         s.rx_prev <= 1'b1;
         s.txo <= 1'b1;
      end
      else
         s <= n;
   end

   // Outputs
   assign rdata = s.rdata;
   assign serial_out_port0 = s.txo;
   assign irq = |(s.ris & s.mask);

   // =========================================================
   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence rx_mid_high;
      s.rxs == RX_START && tick && s.rxt == MID_TICK && rx_line;
   endsequence

   sequence stop_low;
      s.rxs == RX_STOP && rx_end && !rx_line && !rx_full;
   endsequence

   a_tx_start_low: assert property (
      s.txs == TX_START |-> !serial_out_port0)
      else $error("start bit not low");

   a_div_load: assert property (
      bus.wr && bus.addr == OFS_LCRH |=> s.live ==
      {$past(s.ibrd), $past(s.fbrd), $past(bus.wdata[7:0])})
      else $error("divisor not loaded with line control");

   a_div_hold: assert property (
      bus.wr && bus.addr == OFS_IBRD |=> s.live == $past(s.live))
      else $error("divisor took effect early");

   a_busy_push: assert property (
      tx_push && !tx_full |=> busy)
      else $error("busy not set after write");

   a_false_start: assert property (
      rx_mid_high |=> s.rxs == RX_IDLE)
      else $error("false start not ignored");

   a_rx_sample: assert property (
      s.rxs == RX_DATA && rx_end |=> s.rxsh[7] == $past(rx_line))
      else $error("data bit not sampled");

   a_frame_err: assert property (
      stop_low |-> rx_push && rx_wdata.fe ##1 s.ris[IR_FE])
      else $error("framing error not stored");

   a_read_data: assert property (
      bus.rd && bus.addr == OFS_DATA |=>
      rdata[11:0] == $past(rx_head) && rdata[31:12] == 20'h00000)
      else $error("data read wrong");

   a_depth_one: assert property (
      !lc[LC_FIFO] && !rx_empty |-> rx_full)
      else $error("holding register not single entry");

   a_mask_gate: assert property (
      bus.wr && bus.addr == OFS_MASK && bus.wdata[10:0] == 11'h000
      |=> !irq)
      else $error("masked event reached line");

   a_clear_all: assert property (
      bus.wr && bus.addr == OFS_ICR |=>
      (s.ris & $past(bus.wdata[10:0]) & ~$past(set_ev)) == 11'h000)
      else $error("clear did not clear");
endmodule // ast_core

// file: ast_peer.sv
// Remote serial peer model for the async serial core
`timescale 1ns/1ns
module ast_peer
#(
   parameter int BIT_CLKS = 16
)
(
   // Clock
   input wire logic clk,
   // Serial lines
   input wire logic line_in,
   output logic line_out
);
   logic [7:0] rx_buf [0:7];
   int rx_cnt = 0;
   // Idle line stays high, as a pulled-up wire would
   initial line_out = 1'b1;
   // ==========================================================
   // Receive frames, mid-bit sampling
   always
   begin
      @(negedge line_in);
      repeat (BIT_CLKS / 2) @(posedge clk);
      if (line_in === 1'b0)
      begin
         for (int i = 0; i < 8; i++)
         begin
            repeat (BIT_CLKS) @(posedge clk);
            rx_buf[rx_cnt % 8][i] = line_in;
         end
         repeat (BIT_CLKS) @(posedge clk);
         rx_cnt++;
      end
   end
   // ==========================================================
   // Send one frame; a zero byte with a low stop plus hold time gives a break
   task automatic send(input logic [7:0] b, input logic stop, input int hold);
      logic [9:0] f;
      f = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         line_out <= f[i];
         repeat (BIT_CLKS) @(posedge clk);
      end
      repeat (hold) @(posedge clk);
      line_out <= 1'b1;
      repeat (BIT_CLKS) @(posedge clk);
   endtask
   // Short low pulse that the receiver must reject as a false start
   task automatic glitch(input int len);
      line_out <= 1'b0;
      repeat (len) @(posedge clk);
      line_out <= 1'b1;
      repeat (2 * BIT_CLKS) @(posedge clk);
   endtask
endmodule // ast_peer

// file: tb.sv
// Self-checking testbench for the async serial core
`timescale 1ns/1ns
module tb;
   import ast_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   ast_bus_t bus = '0;
   logic [31:0] rdata;
   logic rx_line;
   logic tx_line;
   logic irq;
   logic [31:0] rv;
   int error_cnt = 0;
   int cmp_count = 0;
   // ==========================================================
   // Clock and units; divisor 1.0 gives sixteen clocks a bit
   always #20 clk = ~clk;
   ast_core dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .serial_in_port0(rx_line), .serial_out_port0(tx_line), .irq(irq));
   ast_peer peer (.clk(clk), .line_in(tx_line), .line_out(rx_line));
   // ==========================================================
   // Register port tasks
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [11:0] a);
      @(posedge clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge clk);
      bus.rd <= 1'b0;
      #1 rv = rdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   // Bounded wait for the peer to collect n frames
   task automatic wait_peer(input int n);
      for (int i = 0; i < 2000 && peer.rx_cnt < n; i++) @(posedge clk);
   endtask
   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // ==========================================================
   // Watchdog, far beyond the few thousand cycles of the tests
   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      $display("wrong value at %0t: run hung", $time);
      print_verdict();
   end
   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rd(OFS_CTL);
      chk(rv, 32'h300);
      rd(OFS_FLAG);
      chk(rv, 32'h90);
      rd(OFS_IFLS);
      chk(rv, 32'h12);
      rd(12'h100);
      chk(rv, 32'h0);
      // Setup: disable, divisors, line control, enable
      wr(OFS_CTL, 32'h0);
      wr(OFS_IBRD, 32'h1);
      wr(OFS_FBRD, 32'h0);
      wr(OFS_LCRH, 32'h70);
      wr(OFS_CTL, 32'h301);
      // Back-to-back characters out
      wr(OFS_DATA, 32'ha5);
      wr(OFS_DATA, 32'h3c);
      rd(OFS_FLAG);
      chk(rv & 32'h8, 32'h8);
      wait_peer(2);
      chk({24'h0, peer.rx_buf[0]}, 32'ha5);
      chk({24'h0, peer.rx_buf[1]}, 32'h3c);
      repeat (40) @(posedge clk);
      rd(OFS_FLAG);
      chk(rv, 32'h90);
      // Divisor change without line control write must not apply
      wr(OFS_IBRD, 32'h2);
      peer.send(8'h5a, 1'b1, 0);
      rd(OFS_DATA);
      chk(rv, 32'h05a);
      // Low stop bit
      peer.send(8'h81, 1'b0, 0);
      rd(OFS_DATA);
      chk(rv, 32'h181);
      // Line held low well past a frame
      peer.send(8'h00, 1'b0, 64);
      rd(OFS_DATA);
      chk(rv, 32'h500);
      rd(OFS_RIS);
      chk(rv & 32'h200, 32'h200);
      wr(OFS_ICR, 32'h200);
      rd(OFS_RIS);
      chk(rv & 32'h200, 32'h0);
      // Transmit level event is always up with an empty FIFO
      wr(OFS_MASK, 32'h20);
      rd(OFS_MIS);
      chk(rv, 32'h20);
      chk({31'h0, irq}, 32'h1);
      wr(OFS_MASK, 32'h0);
      #1;
      chk({31'h0, irq}, 32'h0);
      // Loopback returns our own character
      wr(OFS_CTL, 32'h381);
      wr(OFS_DATA, 32'h96);
      wait_peer(3);
      repeat (20) @(posedge clk);
      rd(OFS_DATA);
      chk(rv, 32'h096);
      // Holding registers again, a false start, then an overrun
      wr(OFS_CTL, 32'h0);
      wr(OFS_IBRD, 32'h1);
      wr(OFS_FBRD, 32'h0);
      wr(OFS_LCRH, 32'h60);
      wr(OFS_CTL, 32'h301);
      peer.glitch(4);
      rd(OFS_FLAG);
      chk(rv, 32'h90);
      peer.send(8'h11, 1'b1, 0);
      peer.send(8'h22, 1'b1, 0);
      repeat (600) @(posedge clk);
      rd(OFS_FLAG);
      chk(rv, 32'hc0);
      rd(OFS_RIS);
      chk(rv & 32'h440, 32'h440);
      rd(OFS_RSR);
      chk(rv & 32'h8, 32'h8);
      rd(OFS_DATA);
      chk(rv, 32'h011);
      print_verdict();
   end
endmodule // tb
